/* hw/psam_pkg.sv */
package psam_pkg;
  // Register offsets on the bus (byte addresses)
  localparam logic [7:0] TABLE_PAGE_OFF = 8'h00;
  localparam logic [7:0] VIS_PAGE_OFF = 8'h04;
  localparam logic [7:0] CORE_CTRL_OFF = 8'h08;
  localparam logic [7:0] PC_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] PADDR_OFF = 8'h14;
  localparam logic [7:0] STALL_OFF = 8'h18;
  // Field positions
  localparam int PROG_MSB = 23;
  localparam int CFG_SEL_BIT = 7;
  localparam int VIS_EN_BIT = 2;
  localparam int EA_MSB = 15;
  localparam int WIN_LOW_BITS = 15;
  // Reset values
  localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
  localparam logic [7:0] VIS_PAGE_RST = 8'h00;
  localparam logic [15:0] CORE_CTRL_RST = 16'h0020;
  localparam logic [22:0] PC_RST = 23'h000000;
  // Program counter step per program word
  localparam logic [22:0] PC_STEP = 23'h000002;
  // Extra cycle counts for window accesses
  localparam logic [1:0] PENALTY_SHORT = 2'h1;
  localparam logic [1:0] PENALTY_LONG = 2'h2;
  // Access kinds
  typedef enum logic [2:0] {
    PSAM_ACC_NONE,
    PSAM_ACC_DATA,
    PSAM_ACC_TBL_RD_LOW,
    PSAM_ACC_TBL_RD_HIGH,
    PSAM_ACC_TBL_WR_LOW,
    PSAM_ACC_TBL_WR_HIGH
  } psam_acc_type;
  // Instruction classes for window penalty
  typedef enum logic [1:0] {
    PSAM_CLS_MOVE,
    PSAM_CLS_MOVE_DOUBLE,
    PSAM_CLS_DSP_PREFETCH,
    PSAM_CLS_OTHER
  } psam_cls_type;
endpackage : psam_pkg

/* hw/psam_penalty.sv */
module psam_penalty (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic win_hit,
  input wire psam_pkg::psam_cls_type cls,
  input wire logic in_repeat,
  input wire logic rep_first,
  input wire logic rep_last,
  input wire logic rep_irq_exit,
  input wire logic rep_irq_reentry,
  output logic [1:0] extra_cycles_reg,
  output logic stall_reg
);
  logic [1:0] extra_next;
  logic [1:0] count_reg;

  // ------------------------------------------------------------
  // Penalty choice
  // ------------------------------------------------------------
  always_comb begin
    extra_next = 2'h0;
    if (win_hit) begin
      if (in_repeat) begin
        if (rep_first || rep_last || rep_irq_exit || rep_irq_reentry) begin
          extra_next = psam_pkg::PENALTY_LONG;
        end else begin
          extra_next = 2'h0;
        end
      end else if (cls == psam_pkg::PSAM_CLS_OTHER) begin
        extra_next = psam_pkg::PENALTY_LONG;
      end else begin
        extra_next = psam_pkg::PENALTY_SHORT;
      end
    end
  end

  // ------------------------------------------------------------
  // Stall counter
  // ------------------------------------------------------------
  // New hits are ignored while a stretch is still running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 2'h0;
      extra_cycles_reg <= 2'h0;
    end else if (count_reg != 2'h0) begin
      count_reg <= count_reg - 2'h1;
    end else begin
      count_reg <= extra_next;
      // Held between hits so software can read the last penalty
      if (win_hit) begin
        extra_cycles_reg <= extra_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= 1'b0;
    end else if (count_reg != 2'h0) begin
      stall_reg <= (count_reg != 2'h1);
    end else begin
      stall_reg <= (extra_next != 2'h0);
    end
  end
endmodule : psam_penalty

/* hw/psam_mapper.sv */
// Summary of operation
// - Program addresses are 24 bits from PC, table address or window address.
// - Program counter steps by two per program word; bit 0 stays zero.
// - Non-table program accesses stay in user range with bit 23 clear.
// - Table page bit 7 picks configuration space when set, user when clear.
// - Bit 23 reaches ID and configuration only for table access, else zero.
// - Upper program byte reachable only by high table read and write.
// - Low table read gives bits 15:0, or byte 7:0 / 15:8 by select.
// - High word table read gives bits 23:16 low, upper data byte zero.
// - High byte table read gives bits 23:16 for select 0, zero for 1.
// - Upper 32 Kbytes of data space map onto one 16K-word program page.
// - Window redirect needs data address MSB set and visibility enable set.
// - Window address is low 15 data bits under the 8-bit visibility page.
// - Window read returns only low 16 bits of the program word.
// - Upper data half always belongs to X space, never Y.
// - Window mapping is suspended during table reads and writes.
// - Outside repeat, move, double move, prefetching DSP add one cycle.
// - Outside repeat, other window instructions add two cycles.
// - In repeat, first, last, interrupt exit and reentry add two cycles.
// - Other repeat iterations through the window finish in one cycle.
module psam_mapper (
  input wire logic mclk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core side
  input wire logic acc_valid,
  input wire psam_pkg::psam_acc_type acc_kind,
  input wire logic [15:0] ea,
  input wire logic byte_mode,
  input wire logic [15:0] wr_data,
  input wire logic y_space,
  input wire logic fetch,
  input wire logic pc_load,
  input wire logic [22:0] pc_load_value,
  input wire psam_pkg::psam_cls_type cls,
  input wire logic in_repeat,
  input wire logic rep_first,
  input wire logic rep_last,
  input wire logic rep_irq_exit,
  input wire logic rep_irq_reentry,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic win_active,
  output logic x_space_sel,
  output logic core_stall,
  // Program memory side
  output logic [23:0] prog_addr,
  output logic prog_rd,
  output logic prog_wr_low,
  output logic prog_wr_high,
  output logic [23:0] prog_wdata,
  input wire logic [23:0] prog_rdata
);
  logic [7:0] table_page_register_reg;
  logic [7:0] visibility_page_register_reg;
  logic [15:0] core_control_register_reg;
  logic [22:0] pc_reg;
  logic [23:0] addr_next;
  logic is_table;
  logic win_hit;
  logic rd_pending_reg;
  psam_pkg::psam_acc_type kind_reg;
  logic byte_sel_reg;
  logic byte_mode_reg;
  logic [1:0] extra_cycles;
  logic stall_int;
  logic [7:0] bus_addr_reg;
  logic bus_wr_reg;
  logic bus_act_reg;
  logic bus_wr_en;

  // ------------------------------------------------------------
  // Access decoding
  // ------------------------------------------------------------
  // Both read kinds fetch a program word and return data two edges later
  function automatic logic is_tbl_read(input logic v, input psam_pkg::psam_acc_type k);
    logic r;
    r = (k == psam_pkg::PSAM_ACC_TBL_RD_LOW) || (k == psam_pkg::PSAM_ACC_TBL_RD_HIGH);
    return v && r;
  endfunction : is_tbl_read

  // ------------------------------------------------------------
  // Address construction
  // ------------------------------------------------------------
  assign is_table = acc_valid && (acc_kind != psam_pkg::PSAM_ACC_NONE)
                    && (acc_kind != psam_pkg::PSAM_ACC_DATA);
  assign win_hit = acc_valid && (acc_kind == psam_pkg::PSAM_ACC_DATA)
                   && ea[psam_pkg::EA_MSB]
                   && core_control_register_reg[psam_pkg::VIS_EN_BIT];

  always_comb begin
    if (is_table) begin
      // Page bit 7 lands on bit 23: set picks configuration space
      addr_next = {table_page_register_reg, ea};
    end else if (win_hit) begin
      addr_next = {1'b0, visibility_page_register_reg,
                   ea[psam_pkg::WIN_LOW_BITS-1:0]};
    end else begin
      addr_next = {1'b0, pc_reg};
    end
  end

  // ------------------------------------------------------------
  // Program counter
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= psam_pkg::PC_RST;
    end else if (pc_load) begin
      pc_reg <= {pc_load_value[22:1], 1'b0};
    end else if (fetch && !stall_int) begin
      pc_reg <= pc_reg + psam_pkg::PC_STEP;
    end
  end

  // ------------------------------------------------------------
  // Program memory strobes
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= 24'h000000;
    end else begin
      prog_addr <= addr_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_rd <= 1'b0;
    end else begin
      prog_rd <= win_hit || fetch || is_tbl_read(acc_valid, acc_kind);
    end
  end

  // Separate half strobes, so a low write never touches bits 23:16
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_wr_low <= 1'b0;
      prog_wr_high <= 1'b0;
    end else begin
      prog_wr_low <= acc_valid && (acc_kind == psam_pkg::PSAM_ACC_TBL_WR_LOW);
      prog_wr_high <= acc_valid && (acc_kind == psam_pkg::PSAM_ACC_TBL_WR_HIGH);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_wdata <= 24'h000000;
    end else if (acc_kind == psam_pkg::PSAM_ACC_TBL_WR_HIGH) begin
      prog_wdata <= {wr_data[7:0], 16'h0000};
    end else begin
      prog_wdata <= {8'h00, wr_data};
    end
  end

  // ------------------------------------------------------------
  // Window and space select
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      win_active <= 1'b0;
      x_space_sel <= 1'b1;
    end else begin
      win_active <= win_hit;
      // Upper half is never Y, whatever the caller asks
      x_space_sel <= !y_space || ea[psam_pkg::EA_MSB];
    end
  end

  // ------------------------------------------------------------
  // Read data steering
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= win_hit || is_tbl_read(acc_valid, acc_kind);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      kind_reg <= psam_pkg::PSAM_ACC_NONE;
    end else begin
      kind_reg <= acc_valid ? acc_kind : psam_pkg::PSAM_ACC_NONE;
    end
  end

  // Lane choice kept beside the kind so the data edge steers the right request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_sel_reg <= 1'b0;
      byte_mode_reg <= 1'b0;
    end else begin
      byte_sel_reg <= ea[0];
      byte_mode_reg <= byte_mode;
    end
  end

  function automatic logic [15:0] steer(input psam_pkg::psam_acc_type k,
                                        input logic bm,
                                        input logic bs,
                                        input logic [23:0] p);
    logic [15:0] r;
    r = p[15:0];
    if (k == psam_pkg::PSAM_ACC_TBL_RD_HIGH) begin
      if (bm) begin
        r = bs ? 16'h0000 : {8'h00, p[23:16]};
      end else begin
        r = {8'h00, p[23:16]};
      end
    end else if (k == psam_pkg::PSAM_ACC_TBL_RD_LOW) begin
      if (bm) begin
        r = bs ? {8'h00, p[15:8]} : {8'h00, p[7:0]};
      end else begin
        r = p[15:0];
      end
    end else if (bm) begin
      r = bs ? {8'h00, p[15:8]} : {8'h00, p[7:0]};
    end
    return r;
  endfunction : steer

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_pending_reg;
      if (rd_pending_reg) begin
        rd_data <= steer(kind_reg, byte_mode_reg, byte_sel_reg, prog_rdata);
      end
    end
  end

  // ------------------------------------------------------------
  // Window penalty
  // ------------------------------------------------------------
  psam_penalty u_penalty (
    .mclk(mclk),
    .rst_n(rst_n),
    .win_hit(win_hit),
    .cls(cls),
    .in_repeat(in_repeat),
    .rep_first(rep_first),
    .rep_last(rep_last),
    .rep_irq_exit(rep_irq_exit),
    .rep_irq_reentry(rep_irq_reentry),
    .extra_cycles_reg(extra_cycles),
    .stall_reg(stall_int)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_stall <= 1'b0;
    end else begin
      core_stall <= stall_int;
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite register slave
  // ------------------------------------------------------------
  // Zero wait states; writes commit in the data phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_act_reg <= 1'b0;
    end else if (hready) begin
      bus_act_reg <= hsel && htrans[1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
    end else if (hready) begin
      bus_wr_reg <= hwrite;
      bus_addr_reg <= haddr[7:0];
    end
  end

  assign bus_wr_en = bus_act_reg && bus_wr_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      table_page_register_reg <= psam_pkg::TABLE_PAGE_RST;
    end else if (bus_wr_en && (bus_addr_reg == psam_pkg::TABLE_PAGE_OFF)) begin
      table_page_register_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      visibility_page_register_reg <= psam_pkg::VIS_PAGE_RST;
    end else if (bus_wr_en && (bus_addr_reg == psam_pkg::VIS_PAGE_OFF)) begin
      visibility_page_register_reg <= hwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_control_register_reg <= psam_pkg::CORE_CTRL_RST;
    end else if (bus_wr_en && (bus_addr_reg == psam_pkg::CORE_CTRL_OFF)) begin
      core_control_register_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        psam_pkg::TABLE_PAGE_OFF: hrdata <= {24'h000000, table_page_register_reg};
        psam_pkg::VIS_PAGE_OFF: hrdata <= {24'h000000, visibility_page_register_reg};
        psam_pkg::CORE_CTRL_OFF: hrdata <= {16'h0000, core_control_register_reg};
        psam_pkg::PC_OFF: hrdata <= {9'h000, pc_reg};
        psam_pkg::STATUS_OFF: hrdata <= {29'h00000000, stall_int, win_active, rd_valid};
        psam_pkg::PADDR_OFF: hrdata <= {8'h00, prog_addr};
        psam_pkg::STALL_OFF: hrdata <= {30'h00000000, extra_cycles};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end
endmodule : psam_mapper

/* bench/psam_chk.sv */
// ----------------------------------------
// Checker on the mapper ports
// ----------------------------------------
module psam_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic acc_valid,
  input wire psam_pkg::psam_acc_type acc_kind,
  input wire logic [15:0] ea,
  input wire logic byte_mode,
  input wire psam_pkg::psam_cls_type cls,
  input wire logic in_repeat,
  input wire logic rep_first,
  input wire logic rep_last,
  input wire logic rep_irq_exit,
  input wire logic rep_irq_reentry,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic win_active,
  input wire logic core_stall,
  input wire logic [23:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_wr_low,
  input wire logic prog_wr_high,
  input wire logic [23:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rl;
  logic rh;
  logic rep_any;
  logic other;
  assign rl = acc_kind == psam_pkg::PSAM_ACC_TBL_RD_LOW;
  assign rh = acc_kind == psam_pkg::PSAM_ACC_TBL_RD_HIGH;
  assign rep_any = rep_first | rep_last | rep_irq_exit | rep_irq_reentry;
  assign other = cls == psam_pkg::PSAM_CLS_OTHER;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_user_top_clear: assert property (prog_rd && !$past(rl) && !$past(rh) |-> !prog_addr[23])
    else $error("bit 23 set outside table access");
  chk_table_addr: assert property (acc_valid && (rl || rh)
    |=> prog_rd && prog_addr[15:0] == $past(ea) && !win_active)
    else $error("table address or window suspension wrong");
  chk_win_addr: assert property (win_active
    |-> prog_rd && !prog_addr[23] && prog_addr[14:0] == $past(ea[14:0]))
    else $error("window address wrong");
  chk_win_cause: assert property (win_active
    |-> $past(acc_valid) && $past(acc_kind) == psam_pkg::PSAM_ACC_DATA && $past(ea[15]))
    else $error("window hit without cause");
  chk_low_word: assert property (rd_valid && $past(rl, 2) && !$past(byte_mode, 2)
    |-> rd_data == $past(prog_rdata[15:0]))
    else $error("low word read wrong");
  chk_low_byte: assert property (rd_valid && $past(rl, 2) && $past(byte_mode, 2)
    |-> rd_data[7:0] == ($past(ea[0], 2) ? $past(prog_rdata[15:8]) : $past(prog_rdata[7:0])))
    else $error("low byte lane wrong");
  chk_high_word: assert property (rd_valid && $past(rh, 2) && !$past(byte_mode, 2)
    |-> rd_data == {8'h00, $past(prog_rdata[23:16])})
    else $error("high word read wrong");
  chk_high_byte: assert property (rd_valid && $past(rh, 2) && $past(byte_mode, 2)
    |-> rd_data[7:0] == ($past(ea[0], 2) ? 8'h00 : $past(prog_rdata[23:16])))
    else $error("high byte lane wrong");
  chk_win_read: assert property (rd_valid && $past(win_active) && !$past(byte_mode, 2)
    |-> rd_data == $past(prog_rdata[15:0]))
    else $error("window read wrong");
  chk_wr_low_only: assert property (acc_valid && acc_kind == psam_pkg::PSAM_ACC_TBL_WR_LOW
    |=> prog_wr_low && !prog_wr_high)
    else $error("low table write reached high byte");
  chk_wr_high_only: assert property (
    acc_valid && acc_kind == psam_pkg::PSAM_ACC_TBL_WR_HIGH |=> prog_wr_high && !prog_wr_low)
    else $error("high table write reached low word");
  chk_stall_one: assert property (win_active && !core_stall && !$past(in_repeat) && !$past(other)
    |=> core_stall ##1 !core_stall)
    else $error("short penalty wrong");
  chk_stall_two: assert property (win_active && !core_stall
    && ($past(in_repeat) ? $past(rep_any) : $past(other))
    |=> core_stall [*2] ##1 !core_stall)
    else $error("long penalty wrong");
  chk_stall_none: assert property (win_active && !core_stall && $past(in_repeat) && !$past(rep_any)
    |=> !core_stall)
    else $error("repeat iteration stalled");
endmodule : psam_chk

bind psam_mapper psam_chk u_chk (.mclk, .rst_n, .acc_valid, .acc_kind, .ea, .byte_mode, .cls,
  .in_repeat, .rep_first, .rep_last, .rep_irq_exit, .rep_irq_reentry, .rd_data, .rd_valid,
  .win_active, .core_stall, .prog_addr, .prog_rd, .prog_wr_low, .prog_wr_high, .prog_rdata);

/* bench/psam_prog_mem.sv */
// ----------------------------------------
// Program memory model
// ----------------------------------------
module psam_prog_mem (
  input wire logic [23:0] prog_addr,
  output logic [23:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Upper byte differs from low word so lane slips show
  assign prog_rdata = {prog_addr[7:0] ^ 8'ha5, prog_addr[15:0] ^ 16'h3c69};
endmodule : psam_prog_mem

/* bench/tb.sv */
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rd_valid, win_active, x_space_sel, core_stall;
  wire prog_rd, prog_wr_low, prog_wr_high;
  wire [15:0] rd_data;
  wire [23:0] prog_addr, prog_wdata, prog_rdata;
  logic acc_valid = 1'b0, byte_mode = 1'b0, y_space = 1'b0, fetch = 1'b0, pc_load = 1'b0;
  psam_pkg::psam_acc_type acc_kind = psam_pkg::PSAM_ACC_NONE;
  psam_pkg::psam_cls_type cls = psam_pkg::PSAM_CLS_MOVE;
  logic [15:0] ea = 16'h0;
  logic [15:0] wr_data = 16'h0;
  logic [22:0] pc_load_value = 23'h0;
  logic in_repeat = 1'b0, rep_first = 1'b0, rep_last = 1'b0;
  logic rep_irq_exit = 1'b0, rep_irq_reentry = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rv;
  logic [23:0] pa, p, wd;
  logic [15:0] rdd, e, tea;
  logic win, xs, rdv, bm;
  logic [2:0] ns, wr;
  // Fields: class, in repeat, first, last, irq exit, reentry, extra cycles
  logic [8:0] pen [10] = '{9'h001, 9'h081, 9'h101, 9'h182, 9'h1e2,
                           9'h1d2, 9'h1ca, 9'h1c6, 9'h040, 9'h1c0};
  psam_pkg::psam_acc_type kinds [2] = '{psam_pkg::PSAM_ACC_TBL_WR_LOW,
                                        psam_pkg::PSAM_ACC_TBL_WR_HIGH};

  psam_mapper dut (.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .acc_valid, .acc_kind, .ea, .byte_mode,
    .wr_data, .y_space, .fetch, .pc_load, .pc_load_value, .cls, .in_repeat, .rep_first,
    .rep_last, .rep_irq_exit, .rep_irq_reentry, .rd_data, .rd_valid, .win_active,
    .x_space_sel, .core_stall, .prog_addr, .prog_rd, .prog_wr_low, .prog_wr_high,
    .prog_wdata, .prog_rdata);
  psam_prog_mem mem (.prog_addr, .prog_rdata);

  initial begin
    forever #4 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Bus and core access tasks
  // ----------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : ahb

  task automatic acc(input psam_pkg::psam_acc_type k, input logic [15:0] a, input logic b);
    @(posedge mclk);
    acc_valid <= 1'b1;
    acc_kind <= k;
    ea <= a;
    byte_mode <= b;
    @(posedge mclk);
    acc_valid <= 1'b0;
    #1;
    pa = prog_addr;
    win = win_active;
    xs = x_space_sel;
    wr = {prog_wr_high, prog_wr_low, prog_rd};
    wd = prog_wdata;
    @(posedge mclk);
    #1;
    rdv = rd_valid;
    rdd = rd_data;
    ns = 3'h0;
    repeat (4) begin
      ns = ns + {2'h0, core_stall};
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
  endtask : acc

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    ahb(1'b0, psam_pkg::TABLE_PAGE_OFF, 32'h0);
    `CHK(rv, 32'h0)
    ahb(1'b0, psam_pkg::CORE_CTRL_OFF, 32'h0);
    `CHK(rv, 32'h20)
    ahb(1'b1, 8'h1c, 32'hffffffff);
    ahb(1'b0, 8'h1c, 32'h0);
    `CHK(rv, 32'h0)
    `CHK(hresp, 1'b0)
    $display("TEST registers done");
    fetch <= 1'b1;
    repeat (3) @(posedge mclk);
    fetch <= 1'b0;
    ahb(1'b0, psam_pkg::PC_OFF, 32'h0);
    `CHK(rv, 32'h6)
    pc_load <= 1'b1;
    pc_load_value <= 23'h000101;
    @(posedge mclk);
    pc_load <= 1'b0;
    ahb(1'b0, psam_pkg::PC_OFF, 32'h0);
    `CHK(rv, 32'h100)
    $display("TEST program counter done");
    ahb(1'b1, psam_pkg::VIS_PAGE_OFF, 32'h05);
    acc(psam_pkg::PSAM_ACC_DATA, 16'h8a10, 1'b0);
    `CHK({win, rdv}, 2'h0)
    ahb(1'b1, psam_pkg::CORE_CTRL_OFF, 32'h24);
    y_space <= 1'b1;
    acc(psam_pkg::PSAM_ACC_DATA, 16'h8a10, 1'b0);
    p = {pa[7:0] ^ 8'ha5, pa[15:0] ^ 16'h3c69};
    `CHK(pa, {1'b0, 8'h05, 15'h0a10})
    `CHK({win, rdv, xs}, 3'h7)
    `CHK(rdd, p[15:0])
    acc(psam_pkg::PSAM_ACC_DATA, 16'h0a10, 1'b0);
    `CHK({win, rdv, xs}, 3'h0)
    y_space <= 1'b0;
    ahb(1'b0, psam_pkg::STALL_OFF, 32'h0);
    `CHK(rv, 32'h1)
    ahb(1'b0, psam_pkg::PADDR_OFF, 32'h0);
    `CHK(rv, 32'h100)
    $display("TEST window done");
    ahb(1'b1, psam_pkg::TABLE_PAGE_OFF, 32'h80);
    for (int i = 0; i < 6; i++) begin
      bm = (i % 3) != 0;
      tea = 16'h9230 + 16'(i * 4) + 16'((i % 3) == 2);
      acc(i < 3 ? psam_pkg::PSAM_ACC_TBL_RD_LOW : psam_pkg::PSAM_ACC_TBL_RD_HIGH, tea, bm);
      p = {tea[7:0] ^ 8'ha5, tea ^ 16'h3c69};
      e = i == 0 ? p[15:0] : i == 1 ? {8'h00, p[7:0]} : i == 2 ? {8'h00, p[15:8]} :
          i == 5 ? 16'h0000 : {8'h00, p[23:16]};
      `CHK(pa, {8'h80, tea})
      `CHK({win, rdv}, 2'h1)
      `CHK(wr, 3'h1)
      `CHK(bm ? {8'h00, rdd[7:0]} : rdd, e)
    end
    ahb(1'b1, psam_pkg::TABLE_PAGE_OFF, 32'h7f);
    acc(psam_pkg::PSAM_ACC_TBL_RD_LOW, 16'h0040, 1'b0);
    `CHK(pa, 24'h7f0040)
    wr_data <= 16'h5aa5;
    for (int i = 0; i < 2; i++) begin
      acc(kinds[i], 16'h0044, 1'b0);
      `CHK(wr, i == 0 ? 3'h2 : 3'h4)
      `CHK(wd, i == 0 ? 24'h005aa5 : 24'ha50000)
      `CHK(pa, 24'h7f0044)
    end
    $display("TEST table access done");
    for (int j = 0; j < 10; j++) begin
      cls <= psam_pkg::psam_cls_type'(pen[j][8:7]);
      {in_repeat, rep_first, rep_last, rep_irq_exit, rep_irq_reentry} <= pen[j][6:2];
      acc(psam_pkg::PSAM_ACC_DATA, 16'h8100, 1'b0);
      `CHK(win, 1'b1)
      `CHK(ns, {1'b0, pen[j][1:0]})
    end
    $display("TEST penalties done");
    end_of_test();
  end
endmodule : tb
